// File: logic/option_byte_loader.sv
`timescale 1ns/1ps
// How it works
// - reload stored option words after every reset
// - six bytes: protect, read, config, data
// - each byte checked against stored complement
// - word holds byte, complement, byte, complement
// - code readable only for A5 with 5A
// - otherwise block reads, protect first 4K
// - user bit 5 picks start area
// - bits 4:3 set reset pin ignore window
// - mode 11 leaves pin as plain io
// - bit 2 zero: reset on standby entry
// - two user data bytes, erased all ones
// - one bit per 1K sector, sixteen sectors
// - bit one writable, bit zero protected
// - program low byte, derive high complement
module option_byte_loader #(
  parameter int IGNORE_128US_CYCLES = option_pkg::IGNORE_128US_CYC,
  parameter int IGNORE_1MS_CYCLES   = option_pkg::IGNORE_1MS_CYC,
  parameter int IGNORE_12MS_CYCLES  = option_pkg::IGNORE_12MS_CYC
) (
  input  wire logic        clk,
  input  wire logic        sys_rst,
  output logic             store_rd_req,
  output logic [1:0]       store_rd_index,
  input  wire logic        store_rd_valid,
  input  wire logic [31:0] store_rd_data,
  input  wire logic        prog_wr,
  input  wire logic [31:0] prog_addr,
  input  wire logic [15:0] prog_halfword,
  output logic             store_wr,
  output logic [1:0]       store_wr_index,
  output logic             store_wr_upper,
  output logic [15:0]      store_wr_data,
  input  wire logic        sw_rd,
  input  wire logic [31:0] sw_addr,
  output logic             sw_rvalid,
  output logic [31:0]      sw_rdata,
  input  wire logic        external_reset_pin_n,
  input  wire logic        standby_entry,
  output logic             loaded,
  output logic             load_error,
  output logic             code_read_enable,
  output logic [15:0]      sector_writable,
  output logic             boot_from_user,
  output logic             reset_pin_enable,
  output logic             gpio_owns_pin,
  output logic             external_reset_req,
  output logic             standby_reset_req,
  output logic [15:0]      user_data
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic pair_ok(input logic [15:0] hw);
    pair_ok = (hw[15:8] == ~hw[7:0]);
  endfunction

  function automatic logic opt_addr(input logic [31:0] a);
    opt_addr = (a[31:4] == option_pkg::PROTECT_USER_ADDR[31:4]);
  endfunction

  option_pkg::loader_state_t s;
  option_pkg::loader_state_t next_s;
  localparam int             FILTER_W_L = option_pkg::FILTER_W;
  logic [FILTER_W_L-1:0]     limit;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    logic [15:0] wp;
    logic [7:0]  usr;
    logic        rp_ok;
    next_s = s;
    wp = 16'h0000;
    usr = 8'h00;
    rp_ok = 1'b0;
    next_s.stby_req = 1'b0;
    next_s.wr = 1'b0;
    next_s.sw_rvalid = 1'b0;
    next_s.pin_meta = external_reset_pin_n;
    next_s.pin_sync = s.pin_meta;
    case (s.st)
      option_pkg::ST_FETCH: begin
        // one word at a time; storage may answer late
        next_s.rd_req = 1'b1;
        next_s.rd_idx = s.idx;
        if (s.rd_req && store_rd_valid) begin
          next_s.words[s.idx] = store_rd_data;
          next_s.rd_req = 1'b0;
          if (s.idx == option_pkg::LAST_IDX) begin
            next_s.st = option_pkg::ST_DECODE;
          end else begin
            next_s.idx = s.idx + 2'h1;
          end
        end
      end
      option_pkg::ST_DECODE: begin
        // word layout: byte in low half, complement above
        rp_ok = pair_ok(s.words[option_pkg::PROTECT_USER_IDX][15:0]);
        next_s.cfg.code_readable = rp_ok &&
          (s.words[option_pkg::PROTECT_USER_IDX][7:0] == option_pkg::READ_OPEN_CODE) &&
          (s.words[option_pkg::PROTECT_USER_IDX][15:8] == option_pkg::READ_OPEN_COMP);
        usr = pair_ok(s.words[option_pkg::PROTECT_USER_IDX][31:16]) ?
              s.words[option_pkg::PROTECT_USER_IDX][23:16] : option_pkg::USER_RESET;
        next_s.cfg.boot_from_user = usr[option_pkg::BOOT_SEL_BIT];
        next_s.cfg.reset_mode = usr[option_pkg::RST_MODE_LSB +: 2];
        next_s.cfg.reset_pin_enable = (usr[option_pkg::RST_MODE_LSB +: 2] != option_pkg::RST_MODE_GPIO);
        next_s.cfg.gpio_owns = (usr[option_pkg::RST_MODE_LSB +: 2] == option_pkg::RST_MODE_GPIO);
        next_s.cfg.standby_no_reset = usr[option_pkg::STANDBY_BIT];
        next_s.cfg.user_data[7:0] = pair_ok(s.words[option_pkg::USER_DATA_IDX][15:0]) ?
          s.words[option_pkg::USER_DATA_IDX][7:0] : option_pkg::DATA_RESET[7:0];
        next_s.cfg.user_data[15:8] = pair_ok(s.words[option_pkg::USER_DATA_IDX][31:16]) ?
          s.words[option_pkg::USER_DATA_IDX][23:16] : option_pkg::DATA_RESET[15:8];
        // a corrupted protect byte fails safe: all its sectors protected
        wp[7:0] = pair_ok(s.words[option_pkg::WRITE_PROTECT_IDX][15:0]) ?
          s.words[option_pkg::WRITE_PROTECT_IDX][7:0] : option_pkg::WRITE_PROT_CORRUPT[7:0];
        wp[15:8] = pair_ok(s.words[option_pkg::WRITE_PROTECT_IDX][31:16]) ?
          s.words[option_pkg::WRITE_PROTECT_IDX][23:16] : option_pkg::WRITE_PROT_CORRUPT[15:8];
        if (!next_s.cfg.code_readable) begin
          wp = wp & ~option_pkg::BOOT_SECTOR_MASK;
        end
        next_s.cfg.sector_writable = wp;
        next_s.load_error = !rp_ok || !pair_ok(s.words[option_pkg::PROTECT_USER_IDX][31:16]) ||
          !pair_ok(s.words[option_pkg::USER_DATA_IDX][15:0]) ||
          !pair_ok(s.words[option_pkg::USER_DATA_IDX][31:16]) ||
          !pair_ok(s.words[option_pkg::WRITE_PROTECT_IDX][15:0]) ||
          !pair_ok(s.words[option_pkg::WRITE_PROTECT_IDX][31:16]);
        next_s.loaded = 1'b1;
        next_s.filt_cnt = option_pkg::FILTER_ZERO;
        next_s.filt_done = 1'b0;
        next_s.st = option_pkg::ST_RUN;
      end
      option_pkg::ST_RUN: begin
        // pin is ignored until the window after loading runs out
        if (!s.filt_done) begin
          if (s.filt_cnt >= limit) begin
            next_s.filt_done = 1'b1;
          end else begin
            next_s.filt_cnt = s.filt_cnt + 21'h000001;
          end
        end
        if (standby_entry && !s.cfg.standby_no_reset) begin
          next_s.stby_req = 1'b1;
        end
      end
      default: begin
        next_s.st = option_pkg::ST_FETCH;
        next_s.idx = option_pkg::PROTECT_USER_IDX;
      end
    endcase
    next_s.ext_rst_req = s.loaded && s.cfg.reset_pin_enable && s.filt_done && !s.pin_sync;
    // programming path: only the low byte is taken
    if (prog_wr && opt_addr(prog_addr) && !prog_addr[0]) begin
      next_s.wr = 1'b1;
      next_s.wr_idx = prog_addr[3:2];
      next_s.wr_upper = prog_addr[1];
      next_s.wr_data = {~prog_halfword[7:0], prog_halfword[7:0]};
    end
    // raw words as loaded; reprogrammed values show after next reset
    if (sw_rd) begin
      next_s.sw_rvalid = 1'b1;
      next_s.sw_rdata = opt_addr(sw_addr) ? s.words[sw_addr[3:2]] : 32'h00000000;
    end
  end

  // window length follows the loaded mode
  always_comb begin
    case (s.cfg.reset_mode)
      option_pkg::RST_MODE_128US: limit = FILTER_W_L'(IGNORE_128US_CYCLES);
      option_pkg::RST_MODE_1MS:   limit = FILTER_W_L'(IGNORE_1MS_CYCLES);
      default:                    limit = FILTER_W_L'(IGNORE_12MS_CYCLES);
    endcase
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s <= '0;
      s.st <= option_pkg::ST_FETCH;
      s.idx <= option_pkg::PROTECT_USER_IDX;
      s.words <= {4{option_pkg::WORD_ERASED}};
      s.cfg.sector_writable <= option_pkg::WRITE_PROT_RESET;
      s.cfg.boot_from_user <= 1'b1;
      // erased defaults until the words are fetched
      s.cfg.reset_mode <= option_pkg::RST_MODE_GPIO;
      s.cfg.gpio_owns <= 1'b1;
      s.cfg.standby_no_reset <= 1'b1;
      s.cfg.user_data <= option_pkg::DATA_RESET;
      s.pin_meta <= 1'b1;
      s.pin_sync <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  assign store_rd_req       = s.rd_req;
  assign store_rd_index     = s.rd_idx;
  assign store_wr           = s.wr;
  assign store_wr_index     = s.wr_idx;
  assign store_wr_upper     = s.wr_upper;
  assign store_wr_data      = s.wr_data;
  assign sw_rvalid          = s.sw_rvalid;
  assign sw_rdata           = s.sw_rdata;
  assign loaded             = s.loaded;
  assign load_error         = s.load_error;
  assign code_read_enable   = s.cfg.code_readable;
  assign sector_writable    = s.cfg.sector_writable;
  assign boot_from_user     = s.cfg.boot_from_user;
  assign reset_pin_enable   = s.cfg.reset_pin_enable;
  assign gpio_owns_pin      = s.cfg.gpio_owns;
  assign external_reset_req = s.ext_rst_req;
  assign standby_reset_req  = s.stby_req;
  assign user_data          = s.cfg.user_data;

  // ----------------------------------------------------------------
  // checks: fetch and decode
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  sequence last_word_s;
    s.st == option_pkg::ST_FETCH && s.rd_req && store_rd_valid && s.idx == option_pkg::LAST_IDX;
  endsequence

  sequence early_word_s;
    store_rd_req && store_rd_valid && store_rd_index != option_pkg::LAST_IDX;
  endsequence

  sequence refetch_s;
    !store_rd_req ##1 store_rd_req;
  endsequence

  reload_done_a: assert property (last_word_s |=> ##1 loaded)
    else $error("option words not applied after fetch");
  fetch_hold_a: assert property (store_rd_req && !store_rd_valid |=>
      store_rd_req && $stable(store_rd_index))
    else $error("fetch request dropped before answer");
  fetch_next_a: assert property (early_word_s |=> refetch_s)
    else $error("next option word not requested");
  readable_code_a: assert property (loaded && code_read_enable |->
      s.words[0][7:0] == option_pkg::READ_OPEN_CODE && s.words[0][15:8] == option_pkg::READ_OPEN_COMP)
    else $error("read granted without open code");
  boot_protect_a: assert property (loaded && !code_read_enable |-> sector_writable[3:0] == 4'h0)
    else $error("first 4K writable while read protected");
  corrupt_flag_a: assert property (loaded && !pair_ok(s.words[0][15:0]) |-> load_error && !code_read_enable)
    else $error("corrupt read protect not flagged");
  corrupt_user_a: assert property (loaded && !pair_ok(s.words[0][31:16]) |->
      load_error && boot_from_user && !reset_pin_enable)
    else $error("corrupt user byte not defaulted");
  corrupt_wp_a: assert property (loaded && !pair_ok(s.words[2][31:16]) |->
      load_error && sector_writable[15:8] == 8'h00)
    else $error("corrupt write protect byte not protecting");
  user_data_a: assert property (loaded && pair_ok(s.words[1][15:0]) && pair_ok(s.words[1][31:16]) |->
      user_data == {s.words[1][23:16], s.words[1][7:0]})
    else $error("user data mismatch");
  sector_map_a: assert property (loaded && code_read_enable && pair_ok(s.words[2][15:0]) &&
      pair_ok(s.words[2][31:16]) |-> sector_writable == {s.words[2][23:16], s.words[2][7:0]})
    else $error("sector write map mismatch");
  boot_sel_a: assert property (loaded && pair_ok(s.words[0][31:16]) |-> boot_from_user == s.words[0][21])
    else $error("start source mismatch");

  // ----------------------------------------------------------------
  // checks: programming and software reads
  // ----------------------------------------------------------------
  prog_complement_a: assert property (prog_wr && opt_addr(prog_addr) && !prog_addr[0] |=>
      store_wr && store_wr_data == {~$past(prog_halfword[7:0]), $past(prog_halfword[7:0])})
    else $error("programmed halfword not byte plus complement");
  prog_refused_a: assert property (prog_wr && (prog_addr[0] || !opt_addr(prog_addr)) |=> !store_wr)
    else $error("refused program address reached storage");
  read_word_a: assert property (sw_rd && opt_addr(sw_addr) |=>
      sw_rvalid && sw_rdata == $past(s.words[sw_addr[3:2]]))
    else $error("option word read mismatch");
  read_outside_a: assert property (sw_rd && !opt_addr(sw_addr) |=> sw_rvalid && sw_rdata == 32'h00000000)
    else $error("read outside option words not zero");

  // ----------------------------------------------------------------
  // checks: reset pin and standby
  // ----------------------------------------------------------------
  standby_reset_a: assert property (loaded && standby_entry && !s.words[0][18] &&
      pair_ok(s.words[0][31:16]) |=> standby_reset_req)
    else $error("standby entry did not request reset");
  no_standby_a: assert property (standby_reset_req |->
      $past(standby_entry) && !$past(s.cfg.standby_no_reset))
    else $error("standby reset without cause");
  standby_idle_a: assert property (!loaded && standby_entry |=> !standby_reset_req)
    else $error("standby reset before options loaded");
  gpio_pin_a: assert property (loaded && s.cfg.reset_mode == 2'h3 |-> gpio_owns_pin && !external_reset_req)
    else $error("pin used for reset in io mode");
  pin_mode_a: assert property (loaded && s.cfg.reset_mode != option_pkg::RST_MODE_GPIO |->
      reset_pin_enable && !gpio_owns_pin)
    else $error("reset pin not enabled in filter mode");
  pin_window_a: assert property (external_reset_req |-> $past(s.filt_done) && reset_pin_enable)
    else $error("reset pin honoured inside ignore window");
  window_quiet_a: assert property (loaded && !s.filt_done |-> !external_reset_req)
    else $error("reset pin honoured before window ends");
  pin_follow_a: assert property (loaded && reset_pin_enable && s.filt_done && !s.pin_sync |=>
      external_reset_req)
    else $error("low reset pin not passed on after window");

endmodule

// File: logic/option_pkg.sv
package option_pkg;

  // ----------------------------------------------------------------
  // option word map
  // ----------------------------------------------------------------
  localparam logic [31:0] PROTECT_USER_ADDR   = 32'h1FFFF800;
  localparam logic [31:0] USER_DATA_ADDR      = 32'h1FFFF804;
  localparam logic [31:0] WRITE_PROTECT_ADDR  = 32'h1FFFF808;
  localparam logic [31:0] RESERVED_ADDR       = 32'h1FFFF80C;
  localparam logic [1:0]  PROTECT_USER_IDX    = 2'h0;
  localparam logic [1:0]  USER_DATA_IDX       = 2'h1;
  localparam logic [1:0]  WRITE_PROTECT_IDX   = 2'h2;
  localparam logic [1:0]  LAST_IDX            = 2'h3;

  // ----------------------------------------------------------------
  // field values and positions
  // ----------------------------------------------------------------
  localparam logic [7:0]  READ_OPEN_CODE      = 8'hA5;
  localparam logic [7:0]  READ_OPEN_COMP      = 8'h5A;
  localparam int          BOOT_SEL_BIT        = 5;
  localparam int          RST_MODE_LSB        = 3;
  localparam int          STANDBY_BIT         = 2;
  localparam logic [1:0]  RST_MODE_GPIO       = 2'h3;
  localparam logic [1:0]  RST_MODE_128US      = 2'h0;
  localparam logic [1:0]  RST_MODE_1MS        = 2'h1;
  localparam logic [15:0] BOOT_SECTOR_MASK    = 16'h000F;

  // ----------------------------------------------------------------
  // values after reset and on a corrupted pair
  // ----------------------------------------------------------------
  localparam logic [31:0] WORD_ERASED         = 32'hFFFFFFFF;
  localparam logic [7:0]  USER_RESET          = 8'hFF;
  localparam logic [15:0] DATA_RESET          = 16'hFFFF;
  localparam logic [15:0] WRITE_PROT_RESET    = 16'hFFFF;
  localparam logic [15:0] WRITE_PROT_CORRUPT  = 16'h0000;

  // ----------------------------------------------------------------
  // reset pin ignore windows
  // ----------------------------------------------------------------
  localparam int          CLK_PERIOD_NS       = 8;
  localparam int          IGNORE_128US_NS     = 128000;
  localparam int          IGNORE_1MS_NS       = 1000000;
  localparam int          IGNORE_12MS_NS      = 12000000;
  localparam int          IGNORE_128US_CYC    = (IGNORE_128US_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          IGNORE_1MS_CYC      = (IGNORE_1MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          IGNORE_12MS_CYC     = (IGNORE_12MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          FILTER_W            = 21;
  localparam logic [FILTER_W-1:0] FILTER_ZERO = 21'h000000;

  typedef enum logic [2:0] {
    ST_FETCH  = 3'b001,
    ST_DECODE = 3'b010,
    ST_RUN    = 3'b100
  } load_state_t;

  typedef struct packed {
    logic        code_readable;
    logic [15:0] sector_writable;
    logic        boot_from_user;
    logic        reset_pin_enable;
    logic        gpio_owns;
    logic [1:0]  reset_mode;
    logic        standby_no_reset;
    logic [15:0] user_data;
  } opt_cfg_t;

  typedef struct packed {
    load_state_t         st;
    logic [1:0]          idx;
    logic [3:0][31:0]    words;
    logic                loaded;
    logic                load_error;
    opt_cfg_t            cfg;
    logic                pin_meta;
    logic                pin_sync;
    logic [FILTER_W-1:0] filt_cnt;
    logic                filt_done;
    logic                ext_rst_req;
    logic                stby_req;
    logic                rd_req;
    logic [1:0]          rd_idx;
    logic                wr;
    logic [1:0]          wr_idx;
    logic                wr_upper;
    logic [15:0]         wr_data;
    logic                sw_rvalid;
    logic [31:0]         sw_rdata;
  } loader_state_t;

endpackage

// File: test/test_option_byte_loader.sv
`timescale 1ns/1ps
module test_option_byte_loader;
  logic        clk;
  logic        sys_rst;
  logic        store_rd_req;
  logic [1:0]  store_rd_index;
  logic        store_rd_valid;
  logic [31:0] store_rd_data;
  logic        prog_wr;
  logic [31:0] prog_addr;
  logic [15:0] prog_halfword;
  logic        store_wr;
  logic [1:0]  store_wr_index;
  logic        store_wr_upper;
  logic [15:0] store_wr_data;
  logic        sw_rd;
  logic [31:0] sw_addr;
  logic        sw_rvalid;
  logic [31:0] sw_rdata;
  logic        external_reset_pin_n;
  logic        standby_entry;
  logic        loaded;
  logic        load_error;
  logic        code_read_enable;
  logic [15:0] sector_writable;
  logic        boot_from_user;
  logic        reset_pin_enable;
  logic        gpio_owns_pin;
  logic        external_reset_req;
  logic        standby_reset_req;
  logic [15:0] user_data;
  logic [31:0] flash [4];
  int          fail_count;
  int          n_checks;
  int          win [3] = '{4, 8, 16};

  option_byte_loader #(.IGNORE_128US_CYCLES(4), .IGNORE_1MS_CYCLES(8), .IGNORE_12MS_CYCLES(16)) dut (
    .clk(clk), .sys_rst(sys_rst), .store_rd_req(store_rd_req), .store_rd_index(store_rd_index),
    .store_rd_valid(store_rd_valid), .store_rd_data(store_rd_data), .prog_wr(prog_wr), .prog_addr(prog_addr),
    .prog_halfword(prog_halfword), .store_wr(store_wr), .store_wr_index(store_wr_index),
    .store_wr_upper(store_wr_upper), .store_wr_data(store_wr_data), .sw_rd(sw_rd), .sw_addr(sw_addr),
    .sw_rvalid(sw_rvalid), .sw_rdata(sw_rdata), .external_reset_pin_n(external_reset_pin_n),
    .standby_entry(standby_entry), .loaded(loaded), .load_error(load_error),
    .code_read_enable(code_read_enable), .sector_writable(sector_writable), .boot_from_user(boot_from_user),
    .reset_pin_enable(reset_pin_enable), .gpio_owns_pin(gpio_owns_pin), .external_reset_req(external_reset_req),
    .standby_reset_req(standby_reset_req), .user_data(user_data));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // ----------------------------------------------------------------
  // option storage: answers a fetch one cycle late, scrambles data otherwise
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    store_rd_valid <= store_rd_req && !store_rd_valid && !sys_rst;
    store_rd_data  <= (store_rd_req && !store_rd_valid) ? flash[store_rd_index] : ~store_rd_data;
  end

  task automatic chk(input string name, input logic [63:0] exp, input logic [63:0] got);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic load(input logic [31:0] w0, input logic [31:0] w1, input logic [31:0] w2);
    int i;
    flash[0] = w0;
    flash[1] = w1;
    flash[2] = w2;
    flash[3] = 32'h00FF00FF;
    @(posedge clk);
    sys_rst <= 1'b1;
    repeat (5) @(posedge clk);
    sys_rst <= 1'b0;
    for (i = 0; i < 100 && loaded !== 1'b1; i++) begin
      @(posedge clk);
      #1;
    end
    chk("loaded", 64'h1, 64'(loaded));
  endtask

  task automatic chk_cfg(input logic [36:0] exp);
    chk("config", 64'(exp), 64'({load_error, code_read_enable, sector_writable, boot_from_user,
                                 reset_pin_enable, gpio_owns_pin, user_data}));
  endtask

  task automatic rd(input logic [31:0] addr, input logic [31:0] exp);
    @(posedge clk);
    sw_rd   <= 1'b1;
    sw_addr <= addr;
    @(posedge clk);
    sw_rd <= 1'b0;
    #1;
    chk("sw_read", {31'h0, 1'b1, exp}, {31'h0, sw_rvalid, sw_rdata});
  endtask

  task automatic prog(input logic [31:0] addr, input logic [15:0] hw, input logic we, input logic [18:0] exp);
    @(posedge clk);
    prog_wr       <= 1'b1;
    prog_addr     <= addr;
    prog_halfword <= hw;
    @(posedge clk);
    prog_wr <= 1'b0;
    #1;
    chk("store_wr", 64'(we), 64'(store_wr));
    if (we) chk("store_wr_fields", 64'(exp), 64'({store_wr_index, store_wr_upper, store_wr_data}));
  endtask

  task automatic standby(input logic exp);
    @(posedge clk);
    standby_entry <= 1'b1;
    @(posedge clk);
    standby_entry <= 1'b0;
    #1;
    chk("standby_reset_req", 64'(exp), 64'(standby_reset_req));
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    print_verdict();
  end

  initial begin
    sys_rst = 1'b1;
    prog_wr = 1'b0;
    prog_addr = 32'h0;
    prog_halfword = 16'h0;
    sw_rd = 1'b0;
    sw_addr = 32'h0;
    external_reset_pin_n = 1'b1;
    standby_entry = 1'b0;
    fail_count = 0;
    n_checks = 0;
    // ----------------------------------------------------------------
    // readable part, start from user area, filter 1ms, reset on standby
    // ----------------------------------------------------------------
    load(32'h14EB5AA5, 32'hED12CB34, 32'h55AAAA55);
    chk_cfg({1'b0, 1'b1, 16'hAA55, 1'b1, 1'b1, 1'b0, 16'h1234});
    rd(option_pkg::PROTECT_USER_ADDR, 32'h14EB5AA5);
    rd(option_pkg::USER_DATA_ADDR, 32'hED12CB34);
    rd(option_pkg::WRITE_PROTECT_ADDR, 32'h55AAAA55);
    rd(option_pkg::RESERVED_ADDR, 32'h00FF00FF);
    rd(32'h1FFFF810, 32'h0);
    prog(32'h1FFFF802, 16'h77C3, 1'b1, {2'h0, 1'b1, 16'h3CC3});
    prog(32'h1FFFF808, 16'hFF0F, 1'b1, {2'h2, 1'b0, 16'hF00F});
    prog(32'h1FFFF805, 16'h0012, 1'b0, 19'h0);
    prog(32'h1FFFF810, 16'h0012, 1'b0, 19'h0);
    standby(1'b1);
    $display("test config_load done");
    // ----------------------------------------------------------------
    // pin held low: request only after each mode's ignore window
    // ----------------------------------------------------------------
    for (int m = 0; m < 3; m++) begin
      @(posedge clk);
      external_reset_pin_n <= 1'b0;
      load({~{3'b110, 2'(m), 3'b011}, {3'b110, 2'(m), 3'b011}, 16'h5AA5}, 32'hED12CB34, 32'h55AAAA55);
      chk("boot_from_user", 64'h0, 64'(boot_from_user));
      repeat (win[m] - 1) @(posedge clk);
      #1;
      chk("ext_req_early", 64'h0, 64'(external_reset_req));
      repeat (8) @(posedge clk);
      #1;
      chk("ext_req_late", 64'h1, 64'(external_reset_req));
      @(posedge clk);
      external_reset_pin_n <= 1'b1;
      repeat (6) @(posedge clk);
      #1;
      chk("ext_req_release", 64'h0, 64'(external_reset_req));
      standby(1'b1);
    end
    $display("test reset_pin_windows done");
    // ----------------------------------------------------------------
    // read protected, pin as plain io, no reset on standby
    // ----------------------------------------------------------------
    @(posedge clk);
    external_reset_pin_n <= 1'b0;
    load(32'h00FFFE01, 32'hED12CB34, 32'h55AAAA55);
    chk_cfg({1'b0, 1'b0, 16'hAA50, 1'b1, 1'b0, 1'b1, 16'h1234});
    repeat (30) @(posedge clk);
    #1;
    chk("ext_req_gpio", 64'h0, 64'(external_reset_req));
    standby(1'b0);
    // corrupted pairs on read-protect, user data low and write-protect high
    load(32'h00FF5BA5, 32'hED120034, 32'h00AAAA55);
    chk_cfg({1'b1, 1'b0, 16'h0050, 1'b1, 1'b0, 1'b1, 16'h12FF});
    $display("test protection done");
    print_verdict();
  end
endmodule
